// [logic/swpm_pkg.sv]
// Shared constants, types and register map of the suspend/wake power manager
package swpm_pkg;

  // Clock and timing
  localparam int PCLK_MHZ        = 125;
  localparam int UC_CLK_LEAD_NS  = 100;
  localparam int UC_CLK_LEAD_CYC = (UC_CLK_LEAD_NS * PCLK_MHZ + 999) / 1000;
  localparam int LEAD_CNT_W      = 4;
  localparam logic [LEAD_CNT_W-1:0] LEAD_LAST = LEAD_CNT_W'(UC_CLK_LEAD_CYC - 1);

  // Register offsets
  localparam logic [11:0] CTRL_OFFSET       = 12'h000;
  localparam logic [11:0] WAKE_CAUSE_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET     = 12'h008;

  // Control field positions
  localparam int CTRL_HALT_BIT     = 0;
  localparam int CTRL_TYPE_BIT     = 1;
  localparam int CTRL_COMP_BIT     = 2;
  localparam int CTRL_COMP_CLK_BIT = 3;
  localparam int CTRL_WIDTH        = 4;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h2;

  // Wake cause field positions
  localparam int CAUSE_BUS_BIT    = 0;
  localparam int CAUSE_REMOTE_BIT = 1;
  localparam int CAUSE_WIDTH      = 2;
  localparam logic [CAUSE_WIDTH-1:0] CAUSE_RESET = 2'h0;

  // Status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OSC_BIT   = 3;
  localparam int STAT_RC_BIT    = 4;
  localparam int STAT_IRQ_BIT   = 5;

  typedef enum logic [2:0] {
    SWPM_RUN       = 3'h0,
    SWPM_SUSPEND   = 3'h1,
    SWPM_OSC_START = 3'h2,
    SWPM_CLK_LEAD  = 3'h3
  } swpm_state_type;

  typedef struct packed {
    logic compression_clock_enable;
    logic compression_enable;
    logic sensor_type_select;
    logic sensor_pulse_halt;
  } swpm_ctrl_type;

  typedef struct packed {
    logic remote;
    logic bus;
  } swpm_cause_type;

endpackage : swpm_pkg

// [logic/swpm_clock_gate.sv]
// Glitch-free clock gate with enable retimed on the low phase
`timescale 1ns/10ps
module swpm_clock_gate (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Gate control
  input  wire logic enable,
  // Gated clock
  output logic      gated_clk
);

  logic enable_low;

  // Enable changes only while clk is low
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_low <= 1'b0;
    end else begin
      enable_low <= enable;
    end
  end

  assign gated_clk = clk & enable_low;

endmodule : swpm_clock_gate

// [logic/swpm_power_manager.sv]
// Suspend/wake power manager with APB register slave
// Function
// - In suspend, oscillator stopped and all functions off except wake logic.
// - On wake, microcontroller clock starts first, then its interrupt is raised.
// - Wake cause is recorded in a readable status flag.
// - Pulse generator off when halt is set and sensor type select is clear.
// - Compression engine gated off when both compression enable bits are clear.
// - Wake alone allowed; suspend only after active-low suspend-ready from microcontroller.
// - Oscillator-running output goes high as soon as oscillator is switched on.
// - Internal clock withheld until the RC timing input crosses its threshold.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module swpm_power_manager (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Bus and wake pins
  input  wire logic        usb_suspend_in,
  input  wire logic        remote_wake_in,
  input  wire logic        uc_suspend_ready_n,
  input  wire logic        clock_release_rc_in,
  // Oscillator and clocks
  output logic             osc_enable_out,
  output logic             osc_running_out,
  output logic             internal_clk_out,
  output logic             uc_clk_out,
  // Microcontroller wake interrupt
  output logic             uc_irq_out,
  // Function power controls
  output logic             functions_active,
  output logic             sensor_pulse_generator_enable,
  output logic             compression_power_enable
);

  swpm_pkg::swpm_state_type state;
  swpm_pkg::swpm_state_type next_state;
  swpm_pkg::swpm_ctrl_type  ctrl;
  swpm_pkg::swpm_cause_type cause;
  logic [1:0]               sync_susp;
  logic [1:0]               sync_wake;
  logic [1:0]               sync_ready_n;
  logic [1:0]               sync_rc;
  logic [swpm_pkg::LEAD_CNT_W-1:0] lead_cnt;
  logic                     osc_on;
  logic                     irq;
  logic                     clk_gate_en;
  logic                     wr_en;
  logic                     rd_en;
  logic                     addr_ok;
  logic                     set_bus;
  logic                     set_remote;
  logic                     clr_bus;
  logic                     clr_remote;
  logic                     irq_set;

  // Pin synchronizers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_susp    <= 2'h0;
      sync_wake    <= 2'h0;
      sync_ready_n <= 2'h3;
      sync_rc      <= 2'h0;
    end else begin
      sync_susp    <= {sync_susp[0], usb_suspend_in};
      sync_wake    <= {sync_wake[0], remote_wake_in};
      sync_ready_n <= {sync_ready_n[0], uc_suspend_ready_n};
      sync_rc      <= {sync_rc[0], clock_release_rc_in};
    end
  end

  // Power state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      swpm_pkg::SWPM_RUN: begin
        if (sync_susp[1] && !sync_ready_n[1]) begin
          next_state = swpm_pkg::SWPM_SUSPEND;
        end
      end
      swpm_pkg::SWPM_SUSPEND: begin
        if (!sync_susp[1] || sync_wake[1]) begin
          next_state = swpm_pkg::SWPM_OSC_START;
        end
      end
      swpm_pkg::SWPM_OSC_START: begin
        if (sync_rc[1]) begin
          next_state = swpm_pkg::SWPM_CLK_LEAD;
        end
      end
      swpm_pkg::SWPM_CLK_LEAD: begin
        if (lead_cnt == swpm_pkg::LEAD_LAST) begin
          next_state = swpm_pkg::SWPM_RUN;
        end
      end
      default: next_state = swpm_pkg::SWPM_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= swpm_pkg::SWPM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Clock lead counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_cnt <= '0;
    end else if (state == swpm_pkg::SWPM_CLK_LEAD) begin
      lead_cnt <= lead_cnt + 1'b1;
    end else begin
      lead_cnt <= '0;
    end
  end

  // Oscillator control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_on <= 1'b1;
    end else begin
      osc_on <= (next_state != swpm_pkg::SWPM_SUSPEND);
    end
  end

  assign osc_enable_out  = osc_on;
  assign osc_running_out = osc_on;

  // Clock gates
  assign clk_gate_en = (state == swpm_pkg::SWPM_RUN) || (state == swpm_pkg::SWPM_CLK_LEAD);

  swpm_clock_gate u_internal_gate (
    .clk       (pclk),
    .rst_n     (presetn),
    .enable    (clk_gate_en),
    .gated_clk (internal_clk_out)
  );

  swpm_clock_gate u_uc_gate (
    .clk       (pclk),
    .rst_n     (presetn),
    .enable    (clk_gate_en),
    .gated_clk (uc_clk_out)
  );

  // APB decode
  assign pready  = 1'b1;
  assign addr_ok = (paddr == swpm_pkg::CTRL_OFFSET) || (paddr == swpm_pkg::WAKE_CAUSE_OFFSET)
                   || (paddr == swpm_pkg::STATUS_OFFSET);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= swpm_pkg::CTRL_RESET;
    end else if (wr_en && paddr == swpm_pkg::CTRL_OFFSET) begin
      ctrl <= pwdata[swpm_pkg::CTRL_WIDTH-1:0];
    end
  end

  // Wake cause flags, set wins over clear
  assign set_bus    = (state == swpm_pkg::SWPM_SUSPEND) && !sync_susp[1];
  assign set_remote = (state == swpm_pkg::SWPM_SUSPEND) && sync_wake[1];
  assign clr_bus    = wr_en && paddr == swpm_pkg::WAKE_CAUSE_OFFSET && pwdata[swpm_pkg::CAUSE_BUS_BIT];
  assign clr_remote = wr_en && paddr == swpm_pkg::WAKE_CAUSE_OFFSET && pwdata[swpm_pkg::CAUSE_REMOTE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= swpm_pkg::CAUSE_RESET;
    end else begin
      cause.bus    <= set_bus || (cause.bus && !clr_bus);
      cause.remote <= set_remote || (cause.remote && !clr_remote);
    end
  end

  // Wake interrupt, raised after the lead, cleared with the cause flags
  assign irq_set = (state == swpm_pkg::SWPM_CLK_LEAD) && (next_state == swpm_pkg::SWPM_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_set || (irq && !(clr_bus || clr_remote));
    end
  end

  assign uc_irq_out = irq;

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      prdata <= 32'h0;
      unique case (paddr)
        swpm_pkg::CTRL_OFFSET: prdata[swpm_pkg::CTRL_WIDTH-1:0] <= ctrl;
        swpm_pkg::WAKE_CAUSE_OFFSET: prdata[swpm_pkg::CAUSE_WIDTH-1:0] <= cause;
        swpm_pkg::STATUS_OFFSET: begin
          prdata[swpm_pkg::STAT_STATE_LSB +: 3] <= state;
          prdata[swpm_pkg::STAT_OSC_BIT]        <= osc_on;
          prdata[swpm_pkg::STAT_RC_BIT]         <= sync_rc[1];
          prdata[swpm_pkg::STAT_IRQ_BIT]        <= irq;
        end
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Function power gating
  assign functions_active = (state == swpm_pkg::SWPM_RUN);
  assign sensor_pulse_generator_enable = functions_active
                                         && !(ctrl.sensor_pulse_halt && !ctrl.sensor_type_select);
  assign compression_power_enable = functions_active
                                    && (ctrl.compression_enable || ctrl.compression_clock_enable);

  // Assertions
  suspend_osc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == swpm_pkg::SWPM_SUSPEND) |-> (!osc_enable_out && !functions_active))
    else $error("oscillator or functions active in suspend");

  irq_after_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(uc_irq_out) |-> $past(state) == swpm_pkg::SWPM_CLK_LEAD && $past(clk_gate_en, 2))
    else $error("interrupt raised before microcontroller clock");

  cause_recorded_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == swpm_pkg::SWPM_SUSPEND && sync_wake[1]) |=> cause.remote)
    else $error("remote wake cause not recorded");

  ppg_halt_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.sensor_pulse_halt && !ctrl.sensor_type_select) |-> !sensor_pulse_generator_enable)
    else $error("pulse generator running while halted");

  comp_gate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl.compression_enable && !ctrl.compression_clock_enable) |-> !compression_power_enable)
    else $error("compression powered with both enables clear");

  suspend_needs_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == swpm_pkg::SWPM_RUN && next_state == swpm_pkg::SWPM_SUSPEND) |-> !sync_ready_n[1])
    else $error("suspend entered without ready");

  osc_running_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == swpm_pkg::SWPM_SUSPEND && next_state == swpm_pkg::SWPM_OSC_START) |=> osc_running_out)
    else $error("oscillator running output late");

  clock_withheld_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == swpm_pkg::SWPM_OSC_START && !sync_rc[1]) |=> !clk_gate_en)
    else $error("clock released before threshold");

  lead_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == swpm_pkg::SWPM_CLK_LEAD) |->
    ##12 (state == swpm_pkg::SWPM_CLK_LEAD && lead_cnt == swpm_pkg::LEAD_LAST) ##1 (state == swpm_pkg::SWPM_RUN))
    else $error("clock lead length wrong");

endmodule : swpm_power_manager

// [testbench/swpm_uc_model.sv]
// Microcontroller model: suspend handshake and clock-before-interrupt watch
`timescale 1ns/10ps
module swpm_uc_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Device side
  input  wire logic uc_clk_out,
  input  wire logic uc_irq_out,
  output logic      uc_suspend_ready_n,
  // Bench control
  input  wire logic want_suspend,
  output int        lead_cnt
);
  int seen_cnt;
  // Ready driven low only when suspend is wanted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uc_suspend_ready_n <= 1'b1;
    else uc_suspend_ready_n <= !want_suspend;
  end
  // Clock pulses seen since the suspend request ended
  always @(posedge uc_clk_out or posedge want_suspend) begin
    if (want_suspend) seen_cnt = 0;
    else seen_cnt = seen_cnt + 1;
  end
  always @(posedge uc_irq_out) lead_cnt = seen_cnt;
endmodule : swpm_uc_model

// [testbench/swpm_power_manager_test.sv]
// Self-checking bench of the suspend/wake power manager
`timescale 1ns/10ps
module swpm_power_manager_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        pready, pslverr, err, usb_suspend_in = 0, remote_wake_in = 0, clock_release_rc_in = 1;
  logic        uc_suspend_ready_n, osc_enable_out, osc_running_out, internal_clk_out, uc_clk_out, uc_irq_out;
  logic        functions_active, spg_en, cpe, want_suspend = 0;
  logic [31:0] prdata;
  int          failures = 0, n_tests = 0, iclk_cnt = 0, lead_cnt, snap;

  always #4 pclk = ~pclk;
  always @(posedge internal_clk_out) iclk_cnt++;

  swpm_power_manager DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .usb_suspend_in(usb_suspend_in), .remote_wake_in(remote_wake_in), .uc_suspend_ready_n(uc_suspend_ready_n),
    .clock_release_rc_in(clock_release_rc_in), .osc_enable_out(osc_enable_out),
    .osc_running_out(osc_running_out), .internal_clk_out(internal_clk_out), .uc_clk_out(uc_clk_out),
    .uc_irq_out(uc_irq_out), .functions_active(functions_active),
    .sensor_pulse_generator_enable(spg_en), .compression_power_enable(cpe));
  swpm_uc_model UC (.pclk(pclk), .presetn(presetn), .uc_clk_out(uc_clk_out), .uc_irq_out(uc_irq_out),
    .uc_suspend_ready_n(uc_suspend_ready_n), .want_suspend(want_suspend), .lead_cnt(lead_cnt));

  task check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdchk

  task test_reset;
    rdchk("ctrl", swpm_pkg::CTRL_OFFSET, 32'h2);
    rdchk("cause", swpm_pkg::WAKE_CAUSE_OFFSET, 32'h0);
    rdchk("status", swpm_pkg::STATUS_OFFSET, 32'h18);
    check("slverr ok", err, 1'b0);
    check("ready", pready, 1'b1);
    rdchk("unmapped", 12'h00c, 32'h0);
    check("slverr", err, 1'b1);
    check("osc", osc_running_out, 1'b1);
  endtask : test_reset

  task test_ctrl;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, swpm_pkg::CTRL_OFFSET, i);
      tick(1);
      check("ppg", spg_en, !(i[0] && !i[1]));
      check("comp", cpe, i[2] || i[3]);
      rdchk("ctrl rb", swpm_pkg::CTRL_OFFSET, i);
    end
  endtask : test_ctrl

  task test_suspend;
    @(posedge pclk);
    usb_suspend_in <= 1'b1;
    tick(10);
    check("no ready", functions_active, 1'b1);
    @(posedge pclk);
    want_suspend <= 1'b1;
    for (int k = 0; k < 20 && functions_active !== 1'b0; k++) tick(1);
    check("osc off", {osc_running_out, osc_enable_out, functions_active}, 3'h0);
    check("fn off", {spg_en, cpe}, 2'h0);
    @(posedge pclk);
    want_suspend <= 1'b0;
    clock_release_rc_in <= 1'b0;
    snap = iclk_cnt;
    tick(10);
    check("clk still", iclk_cnt, snap);
    rdchk("st susp", swpm_pkg::STATUS_OFFSET, 32'h1);
  endtask : test_suspend

  task test_wake(input logic remote);
    @(posedge pclk);
    if (remote) remote_wake_in <= 1'b1;
    else usb_suspend_in <= 1'b0;
    for (int k = 0; k < 20 && osc_running_out !== 1'b1; k++) tick(1);
    check("osc on", osc_running_out, 1'b1);
    snap = iclk_cnt;
    tick(20);
    check("clk held", iclk_cnt, snap);
    rdchk("st osc", swpm_pkg::STATUS_OFFSET, 32'ha);
    clock_release_rc_in <= 1'b1;
    for (int k = 0; k < 40 && uc_irq_out !== 1'b1; k++) tick(1);
    check("irq", {uc_irq_out, functions_active}, 2'h3);
    check("clk first", lead_cnt, swpm_pkg::UC_CLK_LEAD_CYC);
    rdchk("cause", swpm_pkg::WAKE_CAUSE_OFFSET, remote ? 32'h2 : 32'h1);
    rdchk("st run", swpm_pkg::STATUS_OFFSET, 32'h38);
    apb(1'b1, swpm_pkg::WAKE_CAUSE_OFFSET, 32'h3);
    rdchk("cleared", swpm_pkg::WAKE_CAUSE_OFFSET, 32'h0);
    check("irq off", uc_irq_out, 1'b0);
    remote_wake_in <= 1'b0;
    usb_suspend_in <= 1'b0;
  endtask : test_wake

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop;
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    tick(4);
    test_reset;
    test_ctrl;
    test_suspend;
    test_wake(1'b0);
    test_suspend;
    test_wake(1'b1);
    report_and_stop;
  end
endmodule : swpm_power_manager_test
